//--- logic/bsr_board_setup.sv
// Board setup and identification register bank with reset and power commands.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
//
// Added by the designer: the address-and-strobe port.
module bsr_board_setup
  import bsr_pkg::*;
#(
  parameter logic [7:0] OPTION_CODE = OPTION_CODE_DEFAULT,
  parameter logic [7:0] REVISION    = REVISION_DEFAULT
)
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_wd_timeout_event,
  output logic      [7:0]  o_rdata,
  output logic             o_ready_led,
  output logic             o_aux_led,
  output logic             o_watchdog_run_enable,
  output logic             o_watchdog_lock_flag,
  output logic      [2:0]  o_port_pair_power_enable,
  output logic             o_wd_timeout_flag,
  output logic             o_hw_reset_req,
  output logic             o_power_off_req
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0] setup;
  logic       watchdog_lock_flag;
  logic       wd_timeout_flag;
  logic       start_hw;
  logic       start_pwr;
  logic       req_busy;
  logic [7:0] next_setup;

  // Address match helper used by every write decode.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  // ---------------------------------------------------------------------------
  // Command decode on the option code register
  // ---------------------------------------------------------------------------
  // Only the two exact codes act; anything else written here is dropped.
  always_comb begin
    start_hw  = i_wr && hit(i_addr, OFS_OPTION_CODE) && (i_wdata == CMD_HW_RESET);
    start_pwr = i_wr && hit(i_addr, OFS_OPTION_CODE) && (i_wdata == CMD_POWER_OFF);
  end

  // The pulse stretcher keeps the request long enough for board reset logic.
  bsr_req_pulse u_req_pulse (
    .i_ref_clk       (i_ref_clk),
    .i_reset         (i_reset),
    .i_start_hw      (start_hw),
    .i_start_pwr     (start_pwr),
    .o_hw_reset_req  (o_hw_reset_req),
    .o_power_off_req (o_power_off_req),
    .o_busy          (req_busy)
  );

  // ---------------------------------------------------------------------------
  // Setup register
  // ---------------------------------------------------------------------------
  // Bits 4 and 3 are forced to zero; a locked watchdog enable can only be set.
  always_comb begin
    next_setup = i_wdata & SETUP_WR_MASK;
    if (watchdog_lock_flag && setup[SETUP_WATCHDOG_RUN_ENABLE_BIT]) begin
      next_setup[SETUP_WATCHDOG_RUN_ENABLE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      setup <= SETUP_RESET;
    end else if (i_wr && hit(i_addr, OFS_SETUP)) begin
      setup <= next_setup;
    end
  end

  // ---------------------------------------------------------------------------
  // Watchdog lock flag
  // ---------------------------------------------------------------------------
  // Once set the lock is sticky until reset, so a running watchdog stays running.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      watchdog_lock_flag <= 1'b0;
    end else if (i_wr && hit(i_addr, OFS_WD_LOCK) && i_wdata[WD_LOCK_BIT]) begin
      watchdog_lock_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Watchdog timeout status flag
  // ---------------------------------------------------------------------------
  // A reset or power command clears the flag, but a timeout in the same cycle wins.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wd_timeout_flag <= 1'b0;
    end else if (i_wd_timeout_event) begin
      wd_timeout_flag <= 1'b1;
    end else if (start_hw || start_pwr) begin
      wd_timeout_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Data appear the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        OFS_OPTION_CODE: o_rdata <= OPTION_CODE;
        OFS_SETUP:       o_rdata <= setup;
        OFS_REVISION:    o_rdata <= REVISION;
        OFS_WD_LOCK:     o_rdata <= {7'h00, watchdog_lock_flag};
        default:         o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin outputs, straight from the register bits
  // ---------------------------------------------------------------------------
  always_comb begin
    o_ready_led              = setup[SETUP_READY_BIT];
    o_aux_led                = setup[SETUP_AUX_BIT];
    o_watchdog_run_enable    = setup[SETUP_WATCHDOG_RUN_ENABLE_BIT];
    o_watchdog_lock_flag     = watchdog_lock_flag;
    // Each enable feeds one switch that supplies two ports.
    o_port_pair_power_enable = setup[SETUP_USB_LSB +: SETUP_USB_W];
    o_wd_timeout_flag        = wd_timeout_flag;
  end

  // The busy output of the pulse stretcher is only informative here.
  logic unused_busy;
  assign unused_busy = req_busy;

endmodule

//--- logic/bsr_pkg.sv
// Package of offsets, field positions, reset values and command codes for the board setup bank.
package bsr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OFS_OPTION_CODE = 16'h8204;
  localparam logic [15:0] OFS_SETUP       = 16'h8205;
  localparam logic [15:0] OFS_REVISION    = 16'h8206;
  localparam logic [15:0] OFS_WD_LOCK     = 16'h8207;

  // ---------------------------------------------------------------------------
  // Setup register fields and reset value
  // ---------------------------------------------------------------------------
  localparam int unsigned SETUP_READY_BIT = 7;
  localparam int unsigned SETUP_WATCHDOG_RUN_ENABLE_BIT  = 6;
  localparam int unsigned SETUP_AUX_BIT   = 5;
  localparam int unsigned SETUP_USB_LSB   = 0;
  localparam int unsigned SETUP_USB_W     = 3;
  localparam logic [7:0]  SETUP_WR_MASK   = 8'he7;
  localparam logic [7:0]  SETUP_RESET     = 8'h07;
  localparam int unsigned WD_LOCK_BIT     = 0;

  // ---------------------------------------------------------------------------
  // Command codes and identity values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_HW_RESET   = 8'ha5;
  localparam logic [7:0] CMD_POWER_OFF  = 8'h5a;
  // Arbitrary neutral values; the real board values are set at integration.
  localparam logic [7:0] OPTION_CODE_DEFAULT = 8'h3c;
  localparam logic [7:0] REVISION_DEFAULT    = 8'h01;

  // ---------------------------------------------------------------------------
  // Timing: length of the reset and power-off request pulses
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned REQ_PULSE_NS    = 1000;
  localparam int unsigned REQ_PULSE_CYC   =
    (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REQ_CNT_W       = 5;

  // Request sequencer states.
  typedef enum logic [1:0] {
    BSR_IDLE,
    BSR_HW_RESET,
    BSR_POWER_OFF
  } bsr_req_state_t;

endpackage

//--- logic/bsr_req_pulse.sv
// Stretches a one-cycle command into a fixed-length request pulse.
module bsr_req_pulse
  import bsr_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_start_hw,
  input  wire logic i_start_pwr,
  output logic      o_hw_reset_req,
  output logic      o_power_off_req,
  output logic      o_busy
);

  bsr_req_state_t         state;
  logic [REQ_CNT_W-1:0]   count;

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // A second command during a running pulse is ignored; the board is going down anyway.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state <= BSR_IDLE;
      count <= '0;
    end else begin
      case (state)
        BSR_IDLE: begin
          count <= REQ_CNT_W'(REQ_PULSE_CYC - 1);
          if (i_start_hw) begin
            state <= BSR_HW_RESET;
          end else if (i_start_pwr) begin
            state <= BSR_POWER_OFF;
          end
        end
        BSR_HW_RESET, BSR_POWER_OFF: begin
          if (count == '0) begin
            state <= BSR_IDLE;
          end else begin
            count <= count - 1'b1;
          end
        end
        default: begin
          state <= BSR_IDLE;
        end
      endcase
    end
  end

  // Outputs decode straight from the state register, so they are glitch free.
  always_comb begin
    o_hw_reset_req  = (state == BSR_HW_RESET);
    o_power_off_req = (state == BSR_POWER_OFF);
    o_busy          = (state != BSR_IDLE);
  end

endmodule

//--- verif/bsr_board_setup_asserts.sv
// Port-level checker for the board setup register bank.
module bsr_board_setup_asserts
  import bsr_pkg::*;
#(
  parameter logic [7:0] OPTION_CODE = OPTION_CODE_DEFAULT,
  parameter logic [7:0] REVISION    = REVISION_DEFAULT
)
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic [15:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_wd_timeout_event,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_ready_led,
  input wire logic        o_watchdog_run_enable,
  input wire logic        o_watchdog_lock_flag,
  input wire logic [2:0]  o_port_pair_power_enable,
  input wire logic        o_wd_timeout_flag,
  input wire logic        o_hw_reset_req,
  input wire logic        o_power_off_req
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Decoded writes; a command starts a request pulse only while no request pulse runs.
  logic wsu;
  logic wopt;
  logic idle;
  assign wsu  = i_wr && i_addr == OFS_SETUP;
  assign wopt = i_wr && i_addr == OFS_OPTION_CODE;
  assign idle = !o_hw_reset_req && !o_power_off_req;
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  chk_reset_led_off : assert property ($fell(i_reset) |-> !o_ready_led && o_port_pair_power_enable == 3'h7)
    else $error("Setup outputs not at reset values.");
  chk_ready_follows : assert property (wsu |=> o_ready_led == $past(i_wdata[7]))
    else $error("Ready LED does not follow the write.");
  chk_power_pairs : assert property (wsu |=> o_port_pair_power_enable == $past(i_wdata[2:0]))
    else $error("Port power enables do not follow the write.");
  chk_lock_holds_en : assert property (wsu && o_watchdog_lock_flag && o_watchdog_run_enable |=> o_watchdog_run_enable)
    else $error("Locked watchdog enable was cleared.");
  chk_hw_reset_req : assert property (wopt && i_wdata == CMD_HW_RESET && idle |=> o_hw_reset_req [*8])
    else $error("Board reset request missing.");
  chk_power_req : assert property (wopt && i_wdata == CMD_POWER_OFF && idle |=> o_power_off_req [*8])
    else $error("Power-off request missing.");
  chk_flag_cleared : assert property (wopt && (i_wdata == CMD_HW_RESET || i_wdata == CMD_POWER_OFF) && idle && !i_wd_timeout_event |=> !o_wd_timeout_flag)
    else $error("Timeout flag not cleared by command.");
  chk_option_read : assert property (i_rd && i_addr == OFS_OPTION_CODE |=> o_rdata == OPTION_CODE)
    else $error("Option code read wrong.");
  chk_revision_read : assert property (i_rd && i_addr == OFS_REVISION |=> o_rdata == REVISION)
    else $error("Revision read wrong.");
endmodule

bind bsr_board_setup bsr_board_setup_asserts #(.OPTION_CODE(OPTION_CODE), .REVISION(REVISION)) u_chk (.*);

//--- verif/bsr_board_setup_tb.sv
// Self-checking testbench for the board setup register bank.
module bsr_board_setup_tb;
  import bsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, wr, rd, ev, rled, aled, watchdog_run_enable, lock, tflag, hreq, preq;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, d;
  logic [2:0]  usb;
  int          num_errors, n_compared;

  bsr_board_setup DUT (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_wd_timeout_event(ev), .o_rdata(rdata), .o_ready_led(rled),
    .o_aux_led(aled), .o_watchdog_run_enable(watchdog_run_enable), .o_watchdog_lock_flag(lock),
    .o_port_pair_power_enable(usb), .o_wd_timeout_flag(tflag), .o_hw_reset_req(hreq),
    .o_power_off_req(preq));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task summarize;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Each bus call drives once at its own edge, so strobes never double-assign.
  task bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
  endtask
  task wrs(input logic [15:0] a, input logic [7:0] v);
    bus(1'b1, 1'b0, a, v);
    bus(1'b0, 1'b0, a, 8'h00);
    #1;
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task rdc(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    #1;
    chk(rdata, e);
  endtask
  task pulse(input logic s);
    for (int k = 0; k < 21; k++) begin
      chk(s ? preq : hreq, k < 20);
      @(posedge clk);
      #1;
    end
  endtask
  task tev;
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    #1;
    chk(tflag, 1'b1);
  endtask
  function automatic logic [7:0] exp_setup(input logic [7:0] v);
    return v & SETUP_WR_MASK;
  endfunction

  // ---------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Tests need well under 1000 cycles; this cuts a hang short.
  initial begin
    #1000000;
    num_errors++;
    summarize;
  end
  initial begin
    {rst, wr, rd, ev, addr, wdata} = {1'b1, 27'h0};
    num_errors = 0;
    n_compared = 0;
    void'($urandom(726));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_SETUP, SETUP_RESET);
    chk(rled, 1'b0);
    $display("Reset test done");
    rdc(OFS_OPTION_CODE, OPTION_CODE_DEFAULT);
    d = 8'($urandom);
    if (d == CMD_HW_RESET || d == CMD_POWER_OFF) d = 8'h11;
    wrs(OFS_OPTION_CODE, d);
    chk(hreq | preq, 1'b0);
    rdc(OFS_OPTION_CODE, OPTION_CODE_DEFAULT);
    wrs(OFS_REVISION, 8'h00);
    rdc(OFS_REVISION, REVISION_DEFAULT);
    rdc(16'h8208, 8'h00);
    $display("Identity test done");
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      wrs(OFS_SETUP, d);
      chk({rled, watchdog_run_enable, aled, usb}, {d[7:5], d[2:0]});
      rdc(OFS_SETUP, exp_setup(d));
    end
    $display("Setup test done");
    // Software enables the watchdog by read-modify-write, so LED and power bits survive.
    wrs(OFS_SETUP, 8'ha1);
    rdc(OFS_SETUP, 8'ha1);
    wrs(OFS_SETUP, 8'ha1 | 8'h40);
    chk({rled, aled, usb}, 5'h19);
    chk(watchdog_run_enable, 1'b1);
    // Power is switched off and then switched back on, as software is told to do.
    wrs(OFS_SETUP, 8'h80);
    chk(usb, 3'h0);
    wrs(OFS_SETUP, 8'h87);
    chk(usb, 3'h7);
    bus(1'b1, 1'b0, OFS_SETUP, 8'hc7);
    bus(1'b1, 1'b0, OFS_WD_LOCK, 8'h01);
    wrs(OFS_SETUP, 8'h87);
    chk(lock, 1'b1);
    rdc(OFS_SETUP, 8'hc7);
    $display("Lock test done");
    tev;
    wrs(OFS_OPTION_CODE, CMD_POWER_OFF);
    chk({tflag, hreq}, 2'h0);
    pulse(1'b1);
    tev;
    wrs(OFS_OPTION_CODE, CMD_HW_RESET);
    chk(tflag, 1'b0);
    pulse(1'b0);
    $display("Command test done");
    summarize;
  end
endmodule
